// *** core/clkmon_selftest_pkg.sv ***
package clkmon_selftest_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int DETECT_NS = 18000;
   localparam int DETECT_CYC = DETECT_NS * CLK_MHZ / 1000;
   // Two windows fit in the latency bound
   localparam int WIN_CYC = DETECT_CYC / 2;
   localparam int BIST_NS = 150000;
   localparam int BIST_CYC = BIST_NS * CLK_MHZ / 1000;
   localparam int STARTUP_TO_NS = 1000000;
   localparam int RESET_EXT_NS = 2000000;
   localparam int TIMER_W = 17;

   // ----------------------------------------------------------------
   // Clock watches
   // ----------------------------------------------------------------
   localparam int N_MON = 6;
   localparam int CH_SYNC = 0;
   localparam int CH_MAIN = 1;
   localparam int CH_BUCK1 = 2;
   localparam int CH_BUCK2 = 3;
   localparam int CH_BOOST = 4;
   localparam int CH_SRC = 5;
   localparam int CNT_W = 10;
   localparam int MAIN_REF_WIN = 32;
   typedef logic [2:0] bitpos_t;
   typedef logic [CNT_W-1:0] cnt_t;
   localparam bitpos_t STAT_BIT [N_MON] =
      '{3'h2, 3'h0, 3'h3, 3'h4, 3'h6, 3'h1};
   localparam cnt_t WIN_LEN [N_MON] = '{cnt_t'(WIN_CYC),
      cnt_t'(MAIN_REF_WIN), cnt_t'(WIN_CYC), cnt_t'(WIN_CYC),
      cnt_t'(WIN_CYC), cnt_t'(WIN_CYC)};
   localparam cnt_t EXP_CNT [N_MON] =
      '{10'h014, 10'h16B, 10'h014, 10'h014, 10'h014, 10'h014};
   localparam cnt_t WARN_DEV [N_MON] =
      '{10'h002, 10'h012, 10'h002, 10'h002, 10'h002, 10'h002};
   localparam cnt_t ERR_DEV [N_MON] =
      '{10'h004, 10'h024, 10'h004, 10'h004, 10'h004, 10'h004};
   localparam logic [N_MON-1:0] CTRL_RESET = 6'h3E;
   localparam logic ARD_RESET = 1'h0;

   // ----------------------------------------------------------------
   // Self-test comparators
   // ----------------------------------------------------------------
   localparam int N_CMP = 6;
   localparam int CMP_BUCK1_CL = 0;
   localparam int CMP_BUCK2_CL = 1;
   localparam int CMP_BOOST_CL = 2;
   localparam int CMP_INTERNAL_REGULATOR_UV = 3;
   localparam int CMP_INTERNAL_REGULATOR_OV = 4;
   localparam int CMP_OTHER = 5;
   localparam int PHASE_CYC = BIST_CYC / (N_CMP * 4);

   typedef enum logic [7:0] {
      ST_OFF      = 8'h01,
      ST_CLK_WAIT = 8'h02,
      ST_TRIM     = 8'h04,
      ST_PU_BIST  = 8'h08,
      ST_RST_EXT  = 8'h10,
      ST_ACTIVE   = 8'h20,
      ST_SAFE     = 8'h40,
      ST_RUN_BIST = 8'h80
   } dev_state_e;

endpackage

// *** core/clkmon_selftest.sv ***
// Operation
// RQ1 - One analog and six digital clock watches supervise the clock tree.
// RQ2 - Main clock late at power-up: back to off, latch clock and timeout.
// RQ3 - Digital watches start only after an error-free trim download.
// RQ4 - Error bits: main 0, source 1, sync 2, buck1 3, buck2 4, boost 6.
// RQ5 - All digital watches but main set a warning at the same bit.
// RQ6 - Each watch flags clocks running too fast or too slow.
// RQ7 - Main watch reference: loop clock when select is 0, modulation when 1.
// RQ8 - Clock errors are detected within 143 cycles of 8 MHz; the code allows two windows, 450 core cycles (18 us, 144 cycles of 8 MHz), main 64 ref edges.
// RQ9 - After reset all digital watches are on except the sync watch.
// RQ10 - Software may switch digital watches off; the analog watch cannot be.
// RQ11 - Main clock errors set status only, with no state reaction.
// RQ12 - Self-test runs at every power-up and during reset extension.
// RQ13 - The controller may start self-test in active or safe states.
// RQ14 - Each comparator gets two test pulses, both responses checked.
// RQ15 - Current-limit and regulator checks run only before regulators start.
// RQ16 - The power-up self-test takes about 150 us.
// RQ17 - Buck1 or regulator check failure samples the off-state latch bits.
// RQ18 - Failed buck1 current-limit check with config and status set: go off.
// RQ19 - Failed regulator voltage check with config and status set: go off.
// RQ20 - Restart from off: wake high if auto-restart on, else wake rise.
// RQ21 - A regulator over-voltage event forces auto-restart disable to 1.
// RQ22 - Other current-limit failures: flag, continue, go safe after reset.
// RQ23 - Watches count monitored edges over a reference window against limits.
`timescale 1ns/1ps
module clkmon_selftest
   import clkmon_selftest_pkg::*;
#(
   parameter int unsigned STARTUP_TO_CYC = STARTUP_TO_NS * CLK_MHZ / 1000,
   parameter int unsigned RESET_EXT_CYC = RESET_EXT_NS * CLK_MHZ / 1000
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic power_on_reset_condition,
   input wire logic wake_pin,
   input wire logic analog_clock_watch_ok,
   input wire logic sync_in_clk,
   input wire logic buck1_switch_clk,
   input wire logic buck2_switch_clk,
   input wire logic boost_switch_clk,
   input wire logic switching_source_clk,
   input wire logic loop_locked_clk,
   input wire logic modulation_clock,
   input wire logic cmp_response,
   input wire logic internal_regulator_ov_event,
   input wire logic trim_done,
   input wire logic trim_error,
   input wire logic switching_clock_source_select,
   input wire logic ctrl_wr,
   input wire logic [N_MON-1:0] ctrl_wr_data,
   input wire logic ard_wr,
   input wire logic ard_wr_data,
   input wire logic regulator_fail_config,
   input wire logic [2:0] off_latch_status,
   input wire logic status_clr,
   input wire logic [7:0] status_clr_mask,
   input wire logic selftest_start,
   output logic [7:0] clock_error_status,
   output logic [7:0] clock_warning_status,
   output logic [N_MON-1:0] clock_watch_control,
   output logic auto_restart_disable,
   output logic main_clock_startup_error,
   output logic startup_timeout_flag,
   output logic regulators_enable,
   output logic reset_output_low_active,
   output logic test_pulse,
   output logic [2:0] test_select,
   output logic [N_CMP-1:0] selftest_fail,
   output logic selftest_busy,
   output dev_state_e device_state
);
   import clkmon_selftest_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int NPIN = 12;
   localparam int P_PLL = 6;
   localparam int P_MOD = 7;
   localparam int P_WAKE = 8;
   localparam int P_ACLK = 9;
   localparam int P_RESP = 10;
   localparam int P_OV = 11;
   logic [NPIN-1:0] pins;
   logic [NPIN-1:0] s1_q, s2_q, s3_q, filt_q, filt_d, rise;
   // The main watch counts the core clock itself, so its pin slot is idle
   logic clk_sys_watch_tie;

   assign clk_sys_watch_tie = 1'b0;
   assign pins = {internal_regulator_ov_event, cmp_response,
      analog_clock_watch_ok, wake_pin, modulation_clock, loop_locked_clk,
      switching_source_clk, boost_switch_clk, buck2_switch_clk,
      buck1_switch_clk, clk_sys_watch_tie, sync_in_clk};

   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         // Only a change seen by both later stages counts
         filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
      end
   end
   assign rise = filt_d & ~filt_q;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         filt_q <= '0;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
      end
   end

   // ----------------------------------------------------------------
   // Digital clock watches
   // ----------------------------------------------------------------
   logic trim_loaded_q, trim_loaded_d;
   logic [N_MON-1:0] ctrl_q, ctrl_d;
   logic [N_MON-1:0] err_evt, warn_evt;

   for (genvar g = 0; g < N_MON; g++) begin : g_watch
      cnt_t win_q, win_d, cnt_q, cnt_d, total;
      logic mon_evt, ref_evt, run, last;

      // Main watch counts core cycles over reference edges
      assign mon_evt = (g == CH_MAIN) ? 1'b1 : rise[g];
      assign ref_evt = (g != CH_MAIN) ? 1'b1 :
         (switching_clock_source_select ? rise[P_MOD] : rise[P_PLL]); // see RQ7
      assign run = trim_loaded_q & ctrl_q[g]; // see RQ3 // see RQ10
      assign last = ref_evt & (win_q == WIN_LEN[g] - 10'h001);
      assign total = cnt_q + cnt_t'(mon_evt);

      always_comb begin
         win_d = win_q;
         cnt_d = total;
         err_evt[g] = 1'b0;
         warn_evt[g] = 1'b0;
         if (!run) begin
            win_d = '0;
            cnt_d = '0;
         end else if (last) begin // see RQ23 // see RQ8
            win_d = '0;
            cnt_d = '0;
            err_evt[g] = (total > EXP_CNT[g] + ERR_DEV[g]) ||
               (total < EXP_CNT[g] - ERR_DEV[g]); // see RQ6
            warn_evt[g] = (g != CH_MAIN) &&
               ((total > EXP_CNT[g] + WARN_DEV[g]) ||
               (total < EXP_CNT[g] - WARN_DEV[g])); // see RQ5
         end else if (ref_evt) begin
            win_d = win_q + 10'h001;
         end
      end

      always_ff @(posedge clk_sys or posedge sys_rst) begin
         if (sys_rst) begin
            win_q <= '0;
            cnt_q <= '0;
         end else begin
            win_q <= win_d;
            cnt_q <= cnt_d;
         end
      end
   end

   // ----------------------------------------------------------------
   // Status and control
   // ----------------------------------------------------------------
   logic [7:0] err_q, err_d, warn_q, warn_d;
   logic ard_q, ard_d;

   always_comb begin
      err_d = status_clr ? (err_q & ~status_clr_mask) : err_q;
      warn_d = status_clr ? (warn_q & ~status_clr_mask) : warn_q;
      // Set beats clear; main watch errors only show here
      for (int i = 0; i < N_MON; i++) begin
         if (err_evt[i]) begin
            err_d[STAT_BIT[i]] = 1'b1; // see RQ4 // see RQ11
         end
         if (warn_evt[i]) begin
            warn_d[STAT_BIT[i]] = 1'b1;
         end
      end
      ctrl_d = ctrl_wr ? ctrl_wr_data : ctrl_q; // see RQ10
      ard_d = ard_wr ? ard_wr_data : ard_q;
      if (rise[P_OV]) begin
         ard_d = 1'b1; // see RQ21
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         err_q <= '0;
         warn_q <= '0;
         ctrl_q <= CTRL_RESET; // see RQ9
         ard_q <= ARD_RESET;
      end else begin
         err_q <= err_d;
         warn_q <= warn_d;
         ctrl_q <= ctrl_d;
         ard_q <= ard_d;
      end
   end

   // ----------------------------------------------------------------
   // Self-test engine
   // ----------------------------------------------------------------
   logic busy_q, busy_d, pulse_q, pulse_d, go;
   logic [2:0] idx_q, idx_d, go_idx;
   logic [1:0] ph_q, ph_d;
   logic [7:0] ph_cnt_q, ph_cnt_d;
   logic [N_CMP-1:0] fail_q, fail_d;

   always_comb begin
      busy_d = busy_q;
      idx_d = idx_q;
      ph_d = ph_q;
      ph_cnt_d = ph_cnt_q + 8'h01;
      fail_d = fail_q;
      if (go) begin
         busy_d = 1'b1;
         idx_d = go_idx;
         ph_d = 2'h0;
         ph_cnt_d = 8'h00;
         for (int i = 0; i < N_CMP; i++) begin
            if (3'(i) >= go_idx) begin
               fail_d[i] = 1'b0;
            end
         end
      end else if (!busy_q) begin
         ph_cnt_d = 8'h00;
      end else if (ph_cnt_q == 8'(PHASE_CYC - 1)) begin // see RQ16
         ph_cnt_d = 8'h00;
         ph_d = ph_q + 2'h1;
         // Pulse phases expect a high answer, gaps a low one
         if (filt_q[P_RESP] == ph_q[0]) begin
            fail_d[idx_q] = 1'b1; // see RQ14
         end
         if (ph_q == 2'h3) begin
            idx_d = idx_q + 3'h1;
            if (idx_q == 3'(N_CMP - 1)) begin
               busy_d = 1'b0;
            end
         end
      end
      pulse_d = busy_d & ~ph_d[0]; // see RQ14
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
         idx_q <= '0;
         ph_q <= '0;
         ph_cnt_q <= '0;
         fail_q <= '0;
         pulse_q <= 1'b0;
      end else begin
         busy_q <= busy_d;
         idx_q <= idx_d;
         ph_q <= ph_d;
         ph_cnt_q <= ph_cnt_d;
         fail_q <= fail_d;
         pulse_q <= pulse_d;
      end
   end

   // ----------------------------------------------------------------
   // Start-up sequencer
   // ----------------------------------------------------------------
   dev_state_e st_q, st_d, ret_q, ret_d;
   logic [TIMER_W-1:0] tmr_q, tmr_d;
   logic sclk_err_q, sclk_err_d, to_q, to_d;
   logic reg_en_q, reg_en_d, rst_out_q, rst_out_d;
   logic go_off, cl_other;

   // Off-state latch bits pick the reaction
   assign go_off = regulator_fail_config & (
      (fail_q[CMP_BUCK1_CL] & off_latch_status[0]) | // see RQ17 // see RQ18
      (fail_q[CMP_INTERNAL_REGULATOR_UV] & off_latch_status[1]) |  // see RQ19
      (fail_q[CMP_INTERNAL_REGULATOR_OV] & off_latch_status[2]));
   assign cl_other = fail_q[CMP_BUCK2_CL] | fail_q[CMP_BOOST_CL];

   always_comb begin
      st_d = st_q;
      ret_d = ret_q;
      tmr_d = tmr_q + TIMER_W'(1);
      sclk_err_d = sclk_err_q;
      to_d = to_q;
      reg_en_d = reg_en_q;
      rst_out_d = rst_out_q;
      trim_loaded_d = trim_loaded_q;
      go = 1'b0;
      go_idx = 3'h0;
      unique case (st_q)
         ST_OFF: begin
            tmr_d = '0;
            reg_en_d = 1'b0;
            rst_out_d = 1'b0;
            trim_loaded_d = 1'b0;
            if (!power_on_reset_condition &&
               (ard_q ? rise[P_WAKE] : filt_q[P_WAKE])) begin // see RQ20
               st_d = ST_CLK_WAIT;
            end
         end
         ST_CLK_WAIT: begin
            if (filt_q[P_ACLK]) begin // see RQ1
               st_d = ST_TRIM;
            end else if (tmr_q == TIMER_W'(STARTUP_TO_CYC - 1)) begin
               st_d = ST_OFF; // see RQ2
               sclk_err_d = 1'b1;
               to_d = 1'b1;
            end
         end
         ST_TRIM: begin
            if (trim_error) begin
               st_d = ST_OFF;
            end else if (trim_done) begin
               trim_loaded_d = 1'b1; // see RQ3
               st_d = ST_PU_BIST;
               go = 1'b1; // see RQ12
            end
         end
         ST_PU_BIST: begin
            tmr_d = '0;
            if (!busy_q && !go) begin
               if (go_off) begin
                  st_d = ST_OFF;
               end else begin
                  // Regulators on: their checks stay out from here on
                  reg_en_d = 1'b1;
                  st_d = ST_RST_EXT;
                  go = 1'b1; // see RQ12 // see RQ15
                  go_idx = 3'(CMP_OTHER);
               end
            end
         end
         ST_RST_EXT: begin
            if (!busy_q && tmr_q >= TIMER_W'(RESET_EXT_CYC - 1)) begin
               rst_out_d = 1'b1;
               st_d = (cl_other || fail_q[CMP_OTHER]) ?
                  ST_SAFE : ST_ACTIVE; // see RQ22
            end
         end
         ST_ACTIVE, ST_SAFE: begin
            if (selftest_start) begin // see RQ13
               ret_d = st_q;
               st_d = ST_RUN_BIST;
               go = 1'b1;
               go_idx = 3'(CMP_OTHER); // see RQ15
            end
         end
         ST_RUN_BIST: begin
            if (!busy_q && !go) begin
               st_d = fail_q[CMP_OTHER] ? ST_SAFE : ret_q;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= ST_OFF;
         ret_q <= ST_ACTIVE;
         tmr_q <= '0;
         sclk_err_q <= 1'b0;
         to_q <= 1'b0;
         reg_en_q <= 1'b0;
         rst_out_q <= 1'b0;
         trim_loaded_q <= 1'b0;
      end else begin
         st_q <= st_d;
         ret_q <= ret_d;
         tmr_q <= tmr_d;
         sclk_err_q <= sclk_err_d;
         to_q <= to_d;
         reg_en_q <= reg_en_d;
         rst_out_q <= rst_out_d;
         trim_loaded_q <= trim_loaded_d;
      end
   end

   assign clock_error_status = err_q;
   assign clock_warning_status = warn_q;
   assign clock_watch_control = ctrl_q;
   assign auto_restart_disable = ard_q;
   assign main_clock_startup_error = sclk_err_q;
   assign startup_timeout_flag = to_q;
   assign regulators_enable = reg_en_q;
   assign reset_output_low_active = rst_out_q;
   assign test_pulse = pulse_q;
   assign test_select = idx_q;
   assign selftest_fail = fail_q;
   assign selftest_busy = busy_q;
   assign device_state = st_q;

endmodule

// *** tb/clkmon_selftest_props.sv ***
`timescale 1ns/1ps
module clkmon_selftest_props (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic selftest_start,
   input wire logic internal_regulator_ov_event,
   input wire logic ctrl_wr,
   input wire logic [clkmon_selftest_pkg::N_MON-1:0] ctrl_wr_data,
   input wire logic [7:0] clock_error_status,
   input wire logic [7:0] clock_warning_status,
   input wire logic [clkmon_selftest_pkg::N_MON-1:0] clock_watch_control,
   input wire logic auto_restart_disable,
   input wire logic regulators_enable,
   input wire logic test_pulse,
   input wire logic [2:0] test_select,
   input wire logic selftest_busy,
   input wire clkmon_selftest_pkg::dev_state_e device_state
);
   import clkmon_selftest_pkg::*;
   // ------------------------------
   // Pulse width counter
   // ------------------------------
   // Counted, since a repetition of 156 would be unrolled
   int unsigned high_q;
   int unsigned high_d;
   always_comb begin
      high_d = test_pulse ? high_q + 1 : 0;
   end
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         high_q <= 0;
      end else begin
         high_q <= high_d;
      end
   end
   // ------------------------------
   // Properties
   // ------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   sequence s_start;
      device_state == ST_ACTIVE && selftest_start;
   endsequence
   sequence s_run;
      device_state == ST_RUN_BIST && selftest_busy && test_select == 3'h5;
   endsequence
   AST_RESET_VALUES: assert property (
      $fell(sys_rst) |-> clock_watch_control == 6'h3E
         && device_state == ST_OFF && !auto_restart_disable)
      else $error("bad value after reset");
   AST_START_TAKEN: assert property (s_start |=> s_run)
      else $error("self-test start not taken");
   AST_PULSE_LEN: assert property (
      $fell(test_pulse) |-> high_q == PHASE_CYC)
      else $error("test pulse width wrong");
   AST_REG_EN_AFTER_BIST: assert property (
      $rose(regulators_enable) |-> $past(device_state) == ST_PU_BIST)
      else $error("regulators on without self-test");
   AST_CL_NOT_AFTER_EN: assert property (
      regulators_enable && selftest_busy |-> test_select == 3'h5)
      else $error("limit test with regulators on");
   AST_CTRL_WRITE: assert property (
      ctrl_wr |=> clock_watch_control == $past(ctrl_wr_data))
      else $error("watch control write lost");
   AST_STATUS_MAP: assert property (
      (clock_error_status & 8'hA0) == 8'h00
         && (clock_warning_status & 8'hA1) == 8'h00)
      else $error("status bit outside map");
   AST_WARN_FIRST: assert property (
      (clock_error_status & ~$past(clock_error_status)
         & ~clock_warning_status & 8'h5E) == 8'h00)
      else $error("error flag without warning");
   AST_OV_FORCES_ARD: assert property (
      $rose(internal_regulator_ov_event) |-> ##[1:8] auto_restart_disable)
      else $error("restart disable not forced");
endmodule

// *** tb/clkmon_far_side.sv ***
`timescale 1ns/1ps
module clkmon_far_side (
   input int half_ns [7],
   input wire logic test_pulse,
   input wire logic [2:0] test_select,
   input wire logic fail_en,
   input wire logic [2:0] fail_idx,
   output wire logic [6:0] clk_out,
   output wire logic cmp_response
);
   // ------------------------------
   // Clock sources
   // ------------------------------
   // Sync, buck1, buck2, boost, source, loop, modulation
   for (genvar g = 0; g < 7; g++) begin : gen_clk
      logic level;
      initial begin
         level = 1'b0;
         #1;
         forever #(half_ns[g]) level = ~level;
      end
      assign clk_out[g] = level;
   end
   // ------------------------------
   // Comparator under test
   // ------------------------------
   // A broken comparator answers the inverse in every phase
   assign cmp_response = (fail_en && test_select == fail_idx) ?
      ~test_pulse : test_pulse;
endmodule

// *** tb/test_clkmon_selftest.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      check_count++; \
      if ((got) !== (exp)) begin \
         fail_count++; \
         $display("mismatch at %0t got %0h exp %0h", $time, got, exp); \
      end \
   end
module test_clkmon_selftest;
   import clkmon_selftest_pkg::*;
   // ------------------------------
   // Design and far side
   // ------------------------------
   localparam int unsigned STARTUP_TO_CYC = 50;
   localparam int unsigned RESET_EXT_CYC = 200;
   localparam int NOM = 225;
   localparam int REF = 227;
   localparam int FAST = 150;
   localparam int SLOW = 450;
   logic clk_sys, sys_rst, power_on_reset_condition, wake_pin, trim_done;
   logic analog_clock_watch_ok, internal_regulator_ov_event, trim_error;
   logic switching_clock_source_select, ctrl_wr, ard_wr, ard_wr_data;
   logic regulator_fail_config, status_clr, selftest_start, fail_en;
   logic cmp_response, auto_restart_disable, regulators_enable, test_pulse;
   logic main_clock_startup_error, startup_timeout_flag, selftest_busy;
   logic reset_output_low_active, sync_in_clk, buck1_switch_clk;
   logic buck2_switch_clk, boost_switch_clk, switching_source_clk;
   logic loop_locked_clk, modulation_clock;
   logic [N_MON-1:0] ctrl_wr_data, clock_watch_control;
   logic [N_CMP-1:0] selftest_fail;
   logic [2:0] off_latch_status, test_select, fail_idx;
   logic [7:0] status_clr_mask, clock_error_status, clock_warning_status;
   logic [6:0] far_clk;
   dev_state_e device_state;
   int half_ns [7] = '{NOM, NOM, NOM, NOM, NOM, REF, REF};
   int bit_pos [5] = '{2, 3, 4, 6, 1};
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   int pulses = 0;
   assign {modulation_clock, loop_locked_clk, switching_source_clk,
      boost_switch_clk, buck2_switch_clk, buck1_switch_clk,
      sync_in_clk} = far_clk;
   clkmon_selftest #(
      .STARTUP_TO_CYC(STARTUP_TO_CYC),
      .RESET_EXT_CYC(RESET_EXT_CYC)
   ) i_dut (.*);
   clkmon_far_side i_far (.half_ns(half_ns), .test_pulse(test_pulse),
      .test_select(test_select), .fail_en(fail_en), .fail_idx(fail_idx),
      .clk_out(far_clk), .cmp_response(cmp_response));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         fail_count++;
         give_verdict();
      end
   end
   always @(posedge test_pulse) pulses++;
   // ------------------------------
   // Access tasks
   // ------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wait_for(input dev_state_e s, input int lim);
      for (int k = 0; k < lim && device_state !== s; k++) begin
         step(1);
      end
      `CHK(device_state, s)
   endtask
   // Which: 0 watch control, 1 restart disable, 2 clear, 3 self-test
   task automatic strobe(input int which, input logic [7:0] d);
      ctrl_wr_data = d[N_MON-1:0];
      ard_wr_data = d[0];
      status_clr_mask = d;
      {ctrl_wr, ard_wr, status_clr, selftest_start} = 4'(8 >> which);
      step(1);
      {ctrl_wr, ard_wr, status_clr, selftest_start} = 4'h0;
      step(1);
   endtask
   task automatic do_reset(input logic wake);
      sys_rst = 1'b1;
      wake_pin = wake;
      step(12);
      `CHK(clock_watch_control, 6'h3E)
      `CHK({auto_restart_disable, device_state}, 9'h001)
      sys_rst = 1'b0;
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ------------------------------
   // Tests
   // ------------------------------
   initial begin
      sys_rst = 1'b1;
      {power_on_reset_condition, wake_pin, analog_clock_watch_ok, trim_done,
         internal_regulator_ov_event, trim_error,
         switching_clock_source_select} = 7'h00;
      {ctrl_wr, ard_wr, ard_wr_data, regulator_fail_config, status_clr,
         selftest_start, fail_en} = 7'h00;
      {ctrl_wr_data, off_latch_status, fail_idx, status_clr_mask} = 20'h0;
      do_reset(1'b1);
      wait_for(ST_CLK_WAIT, 20);
      wait_for(ST_OFF, 100);
      `CHK({startup_timeout_flag, main_clock_startup_error}, 2'h3)
      // Watches must stay quiet until trim is loaded
      analog_clock_watch_ok = 1'b1;
      half_ns[1] = FAST;
      do_reset(1'b1);
      wait_for(ST_TRIM, 40);
      step(600);
      `CHK(clock_error_status, 8'h00)
      // A failed trim download drops back to off
      trim_error = 1'b1;
      wait_for(ST_OFF, 4);
      trim_error = 1'b0;
      half_ns[1] = NOM;
      trim_done = 1'b1;
      wait_for(ST_RST_EXT, 5000);
      `CHK(regulators_enable, 1'b1)
      wait_for(ST_ACTIVE, 1000);
      `CHK({reset_output_low_active, selftest_fail}, 7'h40)
      `CHK(clock_error_status, 8'h00)
      strobe(0, 8'h3F);
      for (int k = 0; k < 5; k++) begin
         half_ns[k] = k[0] ? SLOW : FAST;
         step(500);
         `CHK(clock_error_status, 8'(1 << bit_pos[k]))
         `CHK(clock_warning_status, 8'(1 << bit_pos[k]))
         half_ns[k] = NOM;
         step(500);
         strobe(2, 8'hFF);
      end
      strobe(0, 8'h3B);
      half_ns[1] = FAST;
      step(500);
      `CHK(clock_error_status, 8'h00)
      half_ns[1] = NOM;
      half_ns[6] = FAST;
      step(800);
      `CHK(clock_error_status, 8'h00)
      switching_clock_source_select = 1'b1;
      step(800);
      `CHK(clock_error_status, 8'h01)
      `CHK(device_state, ST_ACTIVE)
      switching_clock_source_select = 1'b0;
      {fail_en, fail_idx} = 4'hD;
      pulses = 0;
      strobe(3, 8'h00);
      wait_for(ST_SAFE, 700);
      `CHK(pulses, 2)
      `CHK(selftest_fail[5], 1'b1)
      // Buck1 limit fails at power-up, restart only on a wake rise
      {regulator_fail_config, off_latch_status, fail_idx} = 7'h48;
      do_reset(1'b0);
      strobe(1, 8'h01);
      wake_pin = 1'b1;
      wait_for(ST_PU_BIST, 60);
      wait_for(ST_OFF, 4000);
      `CHK(regulators_enable, 1'b0)
      step(100);
      `CHK(device_state, ST_OFF)
      wake_pin = 1'b0;
      step(10);
      wake_pin = 1'b1;
      {off_latch_status, fail_idx} = 6'h24;
      step(10);
      `CHK(device_state !== ST_OFF, 1'b1)
      wait_for(ST_PU_BIST, 60);
      wait_for(ST_OFF, 4000);
      `CHK(regulators_enable, 1'b0)
      strobe(1, 8'h00);
      wait_for(ST_CLK_WAIT, 20);
      internal_regulator_ov_event = 1'b1;
      step(10);
      `CHK(auto_restart_disable, 1'b1)
      internal_regulator_ov_event = 1'b0;
      {regulator_fail_config, fail_idx} = 4'h1;
      do_reset(1'b1);
      wait_for(ST_SAFE, 6000);
      `CHK({reset_output_low_active, regulators_enable}, 2'h3)
      `CHK(selftest_fail, 6'h02)
      give_verdict();
   end
endmodule
bind clkmon_selftest clkmon_selftest_props i_props (.*);
